// ---- core/qdac_pkg.sv ----
// Package with constants and types of the quad converter control path
package qdac_pkg;
	localparam int NUM_CH = 4;
	localparam int CODE_W = 14;
	localparam int GAIN_W = 8;
	localparam int ZERO_W = 9;
	localparam int FRAME_BITS = 24;
	localparam int ADDR_W = 4;
	localparam int CNT_W = 5;
	// Frame field positions, first bit shifted in lands at the top
	localparam int RW_POS = 23;
	localparam int ADDR_LSB = 19;
	localparam int DATA_LSB = 5;
	// Register addresses
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_MON = 4'h1;
	localparam logic [3:0] ADDR_DATA0 = 4'h4;
	localparam logic [3:0] ADDR_ZERO0 = 4'h8;
	localparam logic [3:0] ADDR_GAIN0 = 4'hC;
	// Command register bit positions
	localparam int CMD_LOAD_POS = 0;
	localparam int CMD_RESET_POS = 1;
	localparam int CMD_RANGE_LSB = 2;
	// Reset values
	localparam logic [13:0] CODE_RESET = 14'h0000;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [8:0] ZERO_RESET = 9'h000;
	localparam logic [3:0] RANGE_RESET = 4'hF;
	// Output scaling: code weight 1/16384, zero weight 1/(32*16384)
	localparam int ZERO_SHIFT = 5;
	localparam int GAIN_SHIFT_BIP = 3;
	localparam int GAIN_SHIFT_UNI = 2;
	localparam int FRAC_W = 16;
	localparam int OUT_W = 32;

	typedef struct packed {
		logic rw;
		logic [3:0] addr;
		logic [13:0] data;
	} frame_type;

	typedef struct packed {
		logic [13:0] code;
		logic [7:0] gain;
		logic [8:0] zero;
		logic unipolar;
	} chan_cfg_type;
endpackage

// ---- core/qdac_link_rx.sv ----
// Serial link receiver on the link clock, hands finished frames over by toggle
`timescale 1ns/1ps
`default_nettype none
module qdac_link_rx
	import qdac_pkg::*;
(
	// Reset
	input wire logic arst_n_i,
	// Link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	// Hand-over
	output logic [FRAME_BITS-1:0] frame_o,
	output logic frame_ok_o,
	output logic frame_tgl_o
);
	logic [FRAME_BITS-1:0] shift;
	logic [CNT_W-1:0] count;

	// ==========================================
	// Shift on falling edges while selected
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			count <= '0;
		end else begin
			shift <= {shift[FRAME_BITS-2:0], sdi_i};
			if (count != CNT_W'(FRAME_BITS + 1))
				count <= count + 1'b1;
		end
	end

	// ==========================================
	// Frame ends on the rising edge of select; the toggle needs a known start
	always_ff @(posedge cs_n_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame_o <= '0;
			frame_ok_o <= 1'b0;
			frame_tgl_o <= 1'b0;
		end else begin
			frame_o <= shift;
			frame_ok_o <= (count >= CNT_W'(FRAME_BITS));
			frame_tgl_o <= ~frame_tgl_o;
		end
	end
endmodule
`default_nettype wire

// ---- core/qdac_chan_calc.sv ----
// Per-channel output computation from latch code and trims
`timescale 1ns/1ps
`default_nettype none
module qdac_chan_calc
	import qdac_pkg::*;
(
	// Clock
	input wire logic clk,
	input wire logic rst_n,
	// Channel settings
	input wire chan_cfg_type cfg_i,
	// Result, signed, unit 1/(32*16384) of span, gain factor applied
	output logic signed [OUT_W-1:0] value_o
);
	logic signed [OUT_W-1:0] code_ext;
	logic signed [OUT_W-1:0] base;
	logic signed [OUT_W-1:0] next_value;

	always_comb begin
		if (cfg_i.unipolar)
			code_ext = OUT_W'({1'b0, cfg_i.code});
		else
			code_ext = OUT_W'(signed'(cfg_i.code));
		base = (code_ext <<< ZERO_SHIFT) + OUT_W'(signed'(cfg_i.zero));
		// Gain factor 1 + g/(k*16384), k = 8 or 4, applied by a shift
		if (cfg_i.unipolar)
			next_value = base + ((base * OUT_W'(signed'(cfg_i.gain))) >>> (GAIN_SHIFT_UNI + CODE_W));
		else
			next_value = base + ((base * OUT_W'(signed'(cfg_i.gain))) >>> (GAIN_SHIFT_BIP + CODE_W));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			value_o <= '0;
		else
			value_o <= next_value;
	end
endmodule
`default_nettype wire

// ---- core/qdac_ctrl.sv ----
// Quad converter control path: link, registers, latches, load and outputs
`timescale 1ns/1ps
`default_nettype none
module qdac_ctrl
	import qdac_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic ARST_N_I,
	// Serial link
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic SDI_I,
	// Control pins
	input wire logic LATCH_LOAD_PIN_N_I,
	input wire logic GROUP_A_POLARITY_SELECT_I,
	input wire logic GROUP_B_POLARITY_SELECT_I,
	// Readback
	input wire logic [3:0] RD_ADDR_I,
	output logic [13:0] RD_DATA_O,
	// Converter side
	output logic [CHANNELS*CODE_W-1:0] LATCH_CODE_O,
	output logic [CHANNELS-1:0] RANGE_X4_O,
	output logic [CHANNELS-1:0] UNIPOLAR_O,
	output logic [CHANNELS*OUT_W-1:0] CHAN_VALUE_O
);
	// ==========================================
	// Reset release, so every register on CLOCK_I leaves reset on the same edge
	logic rst_s1, rst_n;
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// ==========================================
	// Link receiver and crossing
	logic [FRAME_BITS-1:0] link_frame;
	logic link_ok, link_tgl;
	qdac_link_rx u_rx (
		.arst_n_i(ARST_N_I),
		.sclk_i(SCLK_I),
		.cs_n_i(CS_N_I),
		.sdi_i(SDI_I),
		.frame_o(link_frame),
		.frame_ok_o(link_ok),
		.frame_tgl_o(link_tgl)
	);

	// Frame toggle: two stages to settle, a third to see the change
	logic tgl_s1, tgl_s2, tgl_s3;
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else begin
			tgl_s1 <= link_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	// Load pin starts at its idle high level, so reset makes no false edge
	logic ld_s1, ld_s2, ld_s3;
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			ld_s1 <= 1'b1;
			ld_s2 <= 1'b1;
			ld_s3 <= 1'b1;
		end else begin
			ld_s1 <= LATCH_LOAD_PIN_N_I;
			ld_s2 <= ld_s1;
			ld_s3 <= ld_s2;
		end
	end

	// Group polarity pins
	logic pa_s1, pa_s2, pb_s1, pb_s2;
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			pa_s1 <= 1'b0;
			pa_s2 <= 1'b0;
			pb_s1 <= 1'b0;
			pb_s2 <= 1'b0;
		end else begin
			pa_s1 <= GROUP_A_POLARITY_SELECT_I;
			pa_s2 <= pa_s1;
			pb_s1 <= GROUP_B_POLARITY_SELECT_I;
			pb_s2 <= pb_s1;
		end
	end

	// Frame words are stable long before the toggle arrives through two flops
	logic frame_evt;
	frame_type fr;
	assign frame_evt = tgl_s2 ^ tgl_s3;
	assign fr = '{rw: link_frame[RW_POS], addr: link_frame[ADDR_LSB +: ADDR_W],
		data: link_frame[DATA_LSB +: CODE_W]};

	logic wr_evt;
	assign wr_evt = frame_evt && link_ok && !fr.rw;

	// ==========================================
	// Decoding
	function automatic logic in_bank(input logic [3:0] a, input logic [3:0] base, input int n);
		in_bank = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < {1'b0, base} + 5'(n));
	endfunction

	// Soft reset wins over every other bit of the same command word
	logic soft_reset;
	logic soft_load_strobe_bit;
	assign soft_reset = wr_evt && fr.addr == ADDR_CMD && fr.data[CMD_RESET_POS];
	assign soft_load_strobe_bit = wr_evt && fr.addr == ADDR_CMD && fr.data[CMD_LOAD_POS];

	logic load_fall;
	assign load_fall = ld_s3 && !ld_s2;

	// ==========================================
	// Registers
	logic [CODE_W-1:0] in_reg [CHANNELS];
	logic [CODE_W-1:0] latch [CHANNELS];
	logic [GAIN_W-1:0] gain_trim [CHANNELS];
	logic [ZERO_W-1:0] zero_trim [CHANNELS];
	logic [CHANNELS-1:0] pending;
	logic [CHANNELS-1:0] range_x4;
	logic [13:0] mon_reg;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			range_x4 <= RANGE_RESET;
		end else if (soft_reset) begin
			range_x4 <= RANGE_RESET;
		end else if (wr_evt && fr.addr == ADDR_CMD) begin
			range_x4 <= fr.data[CMD_RANGE_LSB +: CHANNELS];
		end
	end

	// Monitor word is only stored and read back
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			mon_reg <= CODE_RESET;
		end else if (soft_reset) begin
			mon_reg <= CODE_RESET;
		end else if (wr_evt && fr.addr == ADDR_MON) begin
			mon_reg <= fr.data;
		end
	end

	// ==========================================
	// Write strobes per channel
	function automatic logic hits(input logic [3:0] a, input logic [3:0] base, input int i);
		hits = (a == base + 4'(i));
	endfunction

	logic [CHANNELS-1:0] data_wr;
	logic [CHANNELS-1:0] zero_wr;
	logic [CHANNELS-1:0] gain_wr;
	logic load_evt;
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			data_wr[i] = wr_evt && hits(fr.addr, ADDR_DATA0, i);
			zero_wr[i] = wr_evt && hits(fr.addr, ADDR_ZERO0, i);
			gain_wr[i] = wr_evt && hits(fr.addr, ADDR_GAIN0, i);
		end
	end
	assign load_evt = load_fall || soft_load_strobe_bit;

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++)
				in_reg[i] <= CODE_RESET;
		end else if (soft_reset) begin
			for (int i = 0; i < CHANNELS; i++)
				in_reg[i] <= CODE_RESET;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (data_wr[i])
					in_reg[i] <= fr.data;
			end
		end
	end

	// A write with the load pin low also sets the latch; a write wins over a load
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++)
				latch[i] <= CODE_RESET;
		end else if (soft_reset) begin
			for (int i = 0; i < CHANNELS; i++)
				latch[i] <= CODE_RESET;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (data_wr[i] && !ld_s2)
					latch[i] <= fr.data;
				else if (load_evt && pending[i])
					latch[i] <= in_reg[i];
			end
		end
	end

	// A channel is pending from a write made with the load pin high until the next load
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			pending <= '0;
		end else if (soft_reset) begin
			pending <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (data_wr[i])
					pending[i] <= ld_s2;
				else if (load_evt)
					pending[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++)
				zero_trim[i] <= ZERO_RESET;
		end else if (soft_reset) begin
			for (int i = 0; i < CHANNELS; i++)
				zero_trim[i] <= ZERO_RESET;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (zero_wr[i])
					zero_trim[i] <= fr.data[ZERO_W-1:0];
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++)
				gain_trim[i] <= GAIN_RESET;
		end else if (soft_reset) begin
			for (int i = 0; i < CHANNELS; i++)
				gain_trim[i] <= GAIN_RESET;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (gain_wr[i])
					gain_trim[i] <= fr.data[GAIN_W-1:0];
			end
		end
	end

	// ==========================================
	// Readback, command word shows only its range bits, strobe bits read as zero
	// Trims are sign-extended from their stored width, so written bits above it are not read back
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			RD_DATA_O <= '0;
		end else if (RD_ADDR_I == ADDR_CMD) begin
			RD_DATA_O <= 14'(range_x4) << CMD_RANGE_LSB;
		end else if (RD_ADDR_I == ADDR_MON) begin
			RD_DATA_O <= mon_reg;
		end else if (in_bank(RD_ADDR_I, ADDR_DATA0, CHANNELS)) begin
			RD_DATA_O <= in_reg[2'(RD_ADDR_I - ADDR_DATA0)];
		end else if (in_bank(RD_ADDR_I, ADDR_ZERO0, CHANNELS)) begin
			RD_DATA_O <= 14'(signed'(zero_trim[2'(RD_ADDR_I - ADDR_ZERO0)]));
		end else if (in_bank(RD_ADDR_I, ADDR_GAIN0, CHANNELS)) begin
			RD_DATA_O <= 14'(signed'(gain_trim[2'(RD_ADDR_I - ADDR_GAIN0)]));
		end else begin
			RD_DATA_O <= '0;
		end
	end

	// ==========================================
	// Outputs and per-channel computation
	logic [CHANNELS-1:0] unipolar;
	always_comb begin
		for (int i = 0; i < CHANNELS; i++)
			unipolar[i] = (i < 2) ? pa_s2 : pb_s2;
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			LATCH_CODE_O <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++)
				LATCH_CODE_O[i*CODE_W +: CODE_W] <= latch[i];
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			RANGE_X4_O <= RANGE_RESET;
		end else begin
			RANGE_X4_O <= range_x4;
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			UNIPOLAR_O <= '0;
		end else begin
			UNIPOLAR_O <= unipolar;
		end
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			chan_cfg_type cfg;
			assign cfg = '{code: latch[g], gain: gain_trim[g], zero: zero_trim[g],
				unipolar: unipolar[g]};
			qdac_chan_calc u_calc (
				.clk(CLOCK_I),
				.rst_n(rst_n),
				.cfg_i(cfg),
				.value_o(CHAN_VALUE_O[g*OUT_W +: OUT_W])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// ---- tb/qdac_host_model.sv ----
// Host model that drives the serial link of the converter control path
`timescale 1ns/1ps
`default_nettype none
module qdac_host_model (
	// Serial link
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o
);
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b0;
		sdi_o = 1'b0;
		// One short select pulse so the receiver's bit counter starts clear
		#1;
		cs_n_o = 1'b1;
	end
	// Sends n bits MSB first, extra leading bits are ones; clock idles high
	task automatic send(input logic [23:0] w, input int n);
		int i;
		#3;
		cs_n_o = 1'b0;
		for (i = n - 1; i >= 0; i--) begin
			sdi_o = (i < 24) ? w[i] : 1'b1;
			#80;
			sclk_o = 1'b0;
			#80;
			sclk_o = 1'b1;
		end
		#40;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#120;
	endtask
endmodule
`default_nettype wire

// ---- tb/qdac_ctrl_asserts.sv ----
// Checker of the quad converter control path ports
`timescale 1ns/1ps
`default_nettype none
module qdac_ctrl_asserts
	import qdac_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
) (
	// Inputs
	input wire logic CLOCK_I,
	input wire logic ARST_N_I,
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic SDI_I,
	input wire logic LATCH_LOAD_PIN_N_I,
	input wire logic GROUP_A_POLARITY_SELECT_I,
	input wire logic GROUP_B_POLARITY_SELECT_I,
	input wire logic [3:0] RD_ADDR_I,
	// Outputs
	input wire logic [13:0] RD_DATA_O,
	input wire logic [CHANNELS*CODE_W-1:0] LATCH_CODE_O,
	input wire logic [CHANNELS-1:0] RANGE_X4_O,
	input wire logic [CHANNELS-1:0] UNIPOLAR_O,
	input wire logic [CHANNELS*OUT_W-1:0] CHAN_VALUE_O
);
	// ==========================================
	// Cycles since the last frame end or load pin fall
	logic cs_q;
	logic ld_q;
	logic [4:0] quiet;
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cs_q <= 1'b1;
			ld_q <= 1'b1;
			quiet <= 5'h00;
		end else begin
			cs_q <= CS_N_I;
			ld_q <= LATCH_LOAD_PIN_N_I;
			if ((CS_N_I && !cs_q) || (ld_q && !LATCH_LOAD_PIN_N_I)) begin
				quiet <= 5'h00;
			end else if (quiet != 5'h1F) begin
				quiet <= quiet + 5'h01;
			end
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!ARST_N_I);
	a_reset_values: assert property (
		$rose(ARST_N_I) |-> RANGE_X4_O == 4'hF && LATCH_CODE_O == '0)
		else $error("outputs not at reset values");
	a_group_a_mode: assert property (
		$stable(GROUP_A_POLARITY_SELECT_I)[*8] |-> UNIPOLAR_O[1:0] == {2{GROUP_A_POLARITY_SELECT_I}})
		else $error("group a mode wrong");
	a_group_b_mode: assert property (
		$stable(GROUP_B_POLARITY_SELECT_I)[*8] |-> UNIPOLAR_O[3:2] == {2{GROUP_B_POLARITY_SELECT_I}})
		else $error("group b mode wrong");
	a_cmd_strobe_read: assert property (
		$past(RD_ADDR_I) == ADDR_CMD |-> RD_DATA_O[1:0] == 2'b00)
		else $error("strobe bits read nonzero");
	a_gain_sign_ext: assert property (
		$past(RD_ADDR_I) >= ADDR_GAIN0 |-> RD_DATA_O[13:8] == {6{RD_DATA_O[7]}})
		else $error("gain readback not sign extended");
	a_zero_sign_ext: assert property (
		$past(RD_ADDR_I) inside {[ADDR_ZERO0:4'hB]} |-> RD_DATA_O[13:9] == {5{RD_DATA_O[8]}})
		else $error("offset readback not sign extended");
	a_latch_hold: assert property (
		quiet > 5'd10 |-> $stable(LATCH_CODE_O))
		else $error("latch changed without cause");
	a_range_hold: assert property (
		quiet > 5'd10 |-> $stable(RANGE_X4_O))
		else $error("range bits changed without write");
	c_frame_end: cover property ($rose(CS_N_I));
	c_load_fall: cover property ($fell(LATCH_LOAD_PIN_N_I));
	c_unipolar_a: cover property (UNIPOLAR_O[1:0] == 2'b11);
endmodule
`default_nettype wire

// ---- tb/quad_dac_update_calibration_tb_top.sv ----
// Self-checking bench of the quad converter control path
`timescale 1ns/1ps
`default_nettype none
module quad_dac_update_calibration_tb_top;
	import qdac_pkg::*;
	typedef struct packed {
		logic [3:0] wa;
		logic [13:0] wd;
		logic [3:0] ra;
		logic [13:0] rb;
	} row_type;
	logic clk = 1'b0;
	logic arst_n;
	logic ld_n = 1'b1;
	logic pa = 1'b0;
	logic pb = 1'b1;
	logic [3:0] ra = 4'h0;
	logic sck;
	logic csn;
	logic sdi;
	logic [13:0] rdd;
	logic [55:0] lc;
	logic [3:0] rx4;
	logic [3:0] uni;
	logic [127:0] cv;
	int failures = 0;
	int cmp_count = 0;
	// Write address and data, then readback address and expected value
	row_type rows [9] = '{
		'{4'h4, 14'h1234, 4'h4, 14'h1234},
		'{4'h0, 14'h0015, 4'h0, 14'h0014},
		'{4'h9, 14'h0100, 4'h9, 14'h3F00},
		'{4'hA, 14'h00FF, 4'hA, 14'h00FF},
		'{4'hD, 14'h0080, 4'hD, 14'h3F80},
		'{4'hE, 14'h007F, 4'hE, 14'h007F},
		'{4'h1, 14'h02A5, 4'h1, 14'h02A5},
		'{4'h3, 14'h1111, 4'h4, 14'h1234},
		'{4'hF, 14'h3FFF, 4'hF, 14'h3FFF}
	};
	always #2 clk = ~clk;
	qdac_ctrl dut_u (
		.CLOCK_I(clk), .ARST_N_I(arst_n), .SCLK_I(sck), .CS_N_I(csn), .SDI_I(sdi),
		.LATCH_LOAD_PIN_N_I(ld_n), .GROUP_A_POLARITY_SELECT_I(pa),
		.GROUP_B_POLARITY_SELECT_I(pb), .RD_ADDR_I(ra), .RD_DATA_O(rdd),
		.LATCH_CODE_O(lc), .RANGE_X4_O(rx4), .UNIPOLAR_O(uni), .CHAN_VALUE_O(cv)
	);
	qdac_host_model host_u (.sclk_o(sck), .cs_n_o(csn), .sdi_o(sdi));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string s, input logic [55:0] e, input logic [55:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", s, e, g);
			failures++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [13:0] d, input int n = 24);
		host_u.send({1'b0, a, d, 5'h00}, n);
		tick(12);
	endtask
	task automatic rd(input logic [3:0] a, input logic [13:0] e);
		ra <= a;
		tick(3);
		chk("readback", 56'(e), 56'(rdd));
	endtask
	task automatic cv0(input logic [31:0] e);
		tick(20);
		chk("value ch0", 56'(e), 56'(cv[31:0]));
	endtask
	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// About 21 frames of 4 us each; the limit is a bit over twice that
	initial begin
		#200000;
		failures++;
		end_sim();
	end
	initial begin
		arst_n <= 1'b0;
		tick(12);
		arst_n <= 1'b1;
		tick(8);
		chk("range", 56'hF, 56'(rx4));
		chk("latch", 56'h0, lc);
		chk("modes", 56'hC, 56'(uni));
		rd(ADDR_GAIN0, 14'h0000);
		rd(ADDR_ZERO0, 14'h0000);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra, rows[i].rb);
		end
		chk("range", 56'h5, 56'(rx4));
		chk("latch", 56'h1234, lc);
		wr(4'h5, 14'h0064);
		wr(4'h6, 14'h00C8);
		chk("latch", 56'h1234, lc);
		ld_n <= 1'b0;
		tick(10);
		chk("latch", {14'h0, 14'h00C8, 14'h0064, 14'h1234}, lc);
		wr(4'h7, 14'h0777);
		chk("latch", {14'h0777, 14'h00C8, 14'h0064, 14'h1234}, lc);
		wr(4'h7, 14'h1111, 23);
		host_u.send({1'b1, 4'h7, 14'h2222, 5'h00}, 24);
		tick(12);
		rd(4'h7, 14'h0777);
		wr(4'h6, 14'h0333, 25);
		chk("latch", {14'h0777, 14'h0333, 14'h0064, 14'h1234}, lc);
		wr(ADDR_DATA0, 14'h3FFF);
		cv0(32'hFFFFFFE0);
		pa <= 1'b1;
		cv0(32'h0007FFE0);
		chk("modes", 56'hF, 56'(uni));
		wr(ADDR_ZERO0, 14'h01FF);
		cv0(32'h0007FFDF);
		wr(ADDR_ZERO0, 14'h0000);
		wr(ADDR_DATA0, 14'h1000);
		wr(ADDR_GAIN0, 14'h0005);
		cv0(32'h0002000A);
		pa <= 1'b0;
		pb <= 1'b0;
		cv0(32'h00020005);
		chk("modes", 56'h0, 56'(uni));
		wr(ADDR_CMD, 14'h0002);
		chk("range", 56'hF, 56'(rx4));
		chk("latch", 56'h0, lc);
		rd(ADDR_DATA0, 14'h0000);
		rd(ADDR_GAIN0, 14'h0000);
		end_sim();
	end
endmodule
bind qdac_ctrl qdac_ctrl_asserts #(.CHANNELS(CHANNELS)) chk_u (
	.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .SCLK_I(SCLK_I), .CS_N_I(CS_N_I), .SDI_I(SDI_I),
	.LATCH_LOAD_PIN_N_I(LATCH_LOAD_PIN_N_I), .GROUP_A_POLARITY_SELECT_I(GROUP_A_POLARITY_SELECT_I),
	.GROUP_B_POLARITY_SELECT_I(GROUP_B_POLARITY_SELECT_I), .RD_ADDR_I(RD_ADDR_I),
	.RD_DATA_O(RD_DATA_O), .LATCH_CODE_O(LATCH_CODE_O), .RANGE_X4_O(RANGE_X4_O),
	.UNIPOLAR_O(UNIPOLAR_O), .CHAN_VALUE_O(CHAN_VALUE_O)
);
`default_nettype wire
